/* rtl/cpic_defines.vh */
// constants for the core and peripheral interrupt controller
// How it works
// - seventeen core sources ranked, emulator highest, last user slot lowest.
// - one mask/latch bit per maskable source; vectors 0x20 apart from zero.
// - pending bits ANDed with mask; highest unmasked one is chosen.
// - emulator, reset, power-down ignore mask; disable still blocks power-down.
// - enable and disable instructions switch servicing regardless of mask.
// - servicing is globally disabled after reset.
// - control register holds enable and nesting; nesting lets higher ones preempt.
// - software writes to latch force or cancel pending interrupts.
// - status saved on entry; PC stack 33, loop 8, status 16 deep.
// - stack-level interrupt when PC stack below three or above 28.
// - up to 32 peripheral requests are routed onto core inputs.
// - eight 16-bit route registers, four 4-bit codes each.
// - codes 0x0 to 0xB select user slot of the same index.
// - codes 0xC to 0xF disconnect the source entirely.
// - shared codes OR their sources onto one user slot.
// - after reset no source is tied to any user slot.
`ifndef CPIC_DEFINES_VH
`define CPIC_DEFINES_VH

// =====================================================================
// register indices on the core register port
`define CPIC_ADDR_MASK      4'h0
`define CPIC_ADDR_LATCH     4'h1
`define CPIC_ADDR_CTRL      4'h2
`define CPIC_ADDR_INSVC     4'h3
`define CPIC_ADDR_ROUTE0    4'h4
`define CPIC_ADDR_ROUTE7    4'hB

// =====================================================================
// control register fields
`define CPIC_CTRL_NEST_BIT  0
`define CPIC_CTRL_GIE_BIT   1

// =====================================================================
// latch bit positions
`define CPIC_BIT_RESET      0
`define CPIC_BIT_PDOWN      1
`define CPIC_BIT_STACK      2
`define CPIC_BIT_KERNEL     3
`define CPIC_BIT_USER0      4
`define CPIC_NUM_USER       12

// =====================================================================
// reset values
`define CPIC_MASK_RST       16'h0000
`define CPIC_LATCH_RST      16'h0000
`define CPIC_ROUTE_RST      16'hFFFF
`define CPIC_CODE_LAST_USER 4'hB

// =====================================================================
// vectors and stacks
`define CPIC_VEC_SHIFT      5
`define CPIC_PC_DEPTH       33
`define CPIC_LOOP_DEPTH     8
`define CPIC_STAT_DEPTH     16
`define CPIC_PC_LOW_LIMIT   6'd3
`define CPIC_PC_HIGH_LIMIT  6'd28

`endif

/* rtl/cpic_stack_mem.v */
// small stack memory with registered read port
`timescale 1ns/1ps
`default_nettype none

module cpic_stack_mem #(
  parameter W  = 24,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [W-1:0]  wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [W-1:0]  rd_data
);

  reg [W-1:0] mem_reg [0:D-1];

  // =====================================================================
  // write, and read with new-data bypass so a push shows on top at once
  always @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule // cpic_stack_mem

`default_nettype wire

/* rtl/cpic_top.v */
// core interrupt controller with peripheral route unit
`timescale 1ns/1ps
`default_nettype none
`include "cpic_defines.vh"

module cpic_top (
  input  wire        clk,
  input  wire        rst,
  input  wire [31:0] periph_req,
  input  wire        emu_req,
  input  wire        soft_reset_req,
  input  wire        pdown_req,
  input  wire        kernel_req,
  input  wire        ena_int,
  input  wire        dis_int,
  input  wire        irq_ack,
  input  wire        rti,
  input  wire [23:0] pc_ret,
  input  wire        pc_push,
  input  wire        pc_pop,
  input  wire [23:0] pc_wdata,
  input  wire        loop_push,
  input  wire        loop_pop,
  input  wire [23:0] loop_wdata,
  input  wire [3:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         irq_valid,
  output reg  [3:0]  irq_index,
  output reg  [23:0] irq_vector,
  output reg         emu_irq,
  output wire [23:0] pc_top,
  output wire [23:0] loop_top,
  output reg  [5:0]  pc_count,
  output reg  [3:0]  loop_count,
  output reg  [4:0]  stat_count
);

  // =====================================================================
  // functions
  function [4:0] pick_first;
    input [15:0] v;
    integer i;
    begin
      pick_first = 5'h00;
      for (i = 15; i >= 0; i = i - 1) begin
        if (v[i]) begin
          pick_first = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  function [15:0] one_hot;
    input [3:0] idx;
    begin
      one_hot = 16'h0001 << idx;
    end
  endfunction

  // one write strobe decode shared by mask, latch and control; route writes use route_hit
  function wr_hit;
    input       wr;
    input [3:0] addr;
    input [3:0] want;
    begin
      wr_hit = wr && (addr == want);
    end
  endfunction

  // =====================================================================
  // state
  reg  [15:0] mask_reg;
  reg  [15:0] mask_next;
  reg  [15:0] latch_reg;
  reg  [15:0] latch_next;
  reg  [15:0] insvc_reg;
  reg  [15:0] insvc_next;
  reg  [15:0] route_reg [0:7];
  reg         nest_reg;
  reg         gie_reg;
  reg         gie_next;
  reg         stack_cond_reg;
  reg  [5:0]  pc_count_next;
  reg  [3:0]  loop_count_next;
  reg  [4:0]  stat_count_next;
  reg  [11:0] user_req;
  reg  [15:0] allow;
  reg  [15:0] set_vec;
  wire [15:0] stat_top;
  wire [3:0]  route_idx_w;
  wire [2:0]  route_idx;
  wire        route_hit;
  wire        ack_take;
  wire        rti_take;
  wire        stack_cond;
  wire [4:0]  isvc_pick;
  wire [15:0] cand;
  wire [4:0]  sel;
  wire        pc_wr;
  wire        loop_wr;
  wire        stat_wr;
  integer     n;
  integer     k;
  // separate loop variables for each process, so none has two drivers
  integer     m;
  integer     r;
  wire        wr_mask;
  wire        wr_latch;
  wire        wr_ctrl;

  assign route_idx_w = reg_addr - `CPIC_ADDR_ROUTE0;
  assign route_idx   = route_idx_w[2:0];
  assign route_hit   = (reg_addr >= `CPIC_ADDR_ROUTE0) &&
                       (reg_addr <= `CPIC_ADDR_ROUTE7);

  // =====================================================================
  // register write decode
  assign wr_mask  = wr_hit(reg_wr, reg_addr, `CPIC_ADDR_MASK);
  assign wr_latch = wr_hit(reg_wr, reg_addr, `CPIC_ADDR_LATCH);
  assign wr_ctrl  = wr_hit(reg_wr, reg_addr, `CPIC_ADDR_CTRL);

  // =====================================================================
  // peripheral routing
  // requests are combined level by level, the latch holds them
  always @* begin
    user_req = 12'h000;
    for (n = 0; n < 32; n = n + 1) begin
      for (k = 0; k < `CPIC_NUM_USER; k = k + 1) begin
        if (route_reg[n / 4][(n % 4) * 4 +: 4] == k[3:0]) begin
          user_req[k] = user_req[k] | periph_req[n];
        end
      end
    end
    // codes above the last user slot match no k, so they drop out
  end

  // =====================================================================
  // sources into the latch
  assign stack_cond = (pc_count < `CPIC_PC_LOW_LIMIT) ||
                      (pc_count > `CPIC_PC_HIGH_LIMIT);

  always @* begin
    set_vec = 16'h0000;
    set_vec[`CPIC_BIT_RESET]  = soft_reset_req;
    set_vec[`CPIC_BIT_PDOWN]  = pdown_req;
    // edge only, else an empty stack would request forever
    set_vec[`CPIC_BIT_STACK]  = stack_cond & ~stack_cond_reg;
    set_vec[`CPIC_BIT_KERNEL] = kernel_req;
    set_vec[15:4]             = user_req;
  end

  // =====================================================================
  // selection
  assign isvc_pick = pick_first(insvc_reg);

  always @* begin
    for (m = 0; m < 16; m = m + 1) begin
      allow[m] = !isvc_pick[4] || (m == 0) ||
                 (nest_reg && (m < isvc_pick[3:0]));
    end
  end

  // reset ignores everything; power-down only the global switch
  assign cand = {latch_reg[15:2] & mask_reg[15:2] & {14{gie_reg}},
                 latch_reg[`CPIC_BIT_PDOWN] & gie_reg,
                 latch_reg[`CPIC_BIT_RESET]};
  assign sel  = pick_first(cand & allow);

  assign ack_take = irq_ack && irq_valid;
  // an entry in the same cycle wins, the return is dropped
  assign rti_take = rti && !ack_take && (insvc_reg != 16'h0000);

  // =====================================================================
  // control next state
  always @* begin
    latch_next = latch_reg;
    if (wr_latch) begin
      latch_next = reg_wdata;
    end
    if (ack_take) begin
      latch_next = latch_next & ~one_hot(irq_index);
    end
    latch_next = latch_next | set_vec; // set beats clear

    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = reg_wdata;
    end
    if (rti_take && (stat_count != 5'd0)) begin
      mask_next = stat_top;
    end

    insvc_next = insvc_reg;
    if (ack_take) begin
      insvc_next = insvc_reg | one_hot(irq_index);
    end else if (rti_take) begin
      insvc_next = insvc_reg & ~one_hot(isvc_pick[3:0]);
    end

    gie_next = gie_reg;
    if (ena_int) begin
      gie_next = 1'b1;
    end
    if (dis_int) begin
      gie_next = 1'b0;
    end
  end

  // =====================================================================
  // stack pointers, one operation per stack per cycle
  assign pc_wr   = (ack_take || pc_push) && (pc_count < `CPIC_PC_DEPTH);
  assign stat_wr = ack_take && (stat_count < `CPIC_STAT_DEPTH);
  assign loop_wr = loop_push && (loop_count < `CPIC_LOOP_DEPTH);

  always @* begin
    pc_count_next = pc_count;
    if (pc_wr) begin
      pc_count_next = pc_count + 6'd1;
    end else if ((rti_take || pc_pop) && (pc_count != 6'd0)) begin
      pc_count_next = pc_count - 6'd1;
    end
    stat_count_next = stat_count;
    if (stat_wr) begin
      stat_count_next = stat_count + 5'd1;
    end else if (rti_take && (stat_count != 5'd0)) begin
      stat_count_next = stat_count - 5'd1;
    end
    loop_count_next = loop_count;
    if (loop_wr) begin
      loop_count_next = loop_count + 4'd1;
    end else if (loop_pop && (loop_count != 4'd0)) begin
      loop_count_next = loop_count - 4'd1;
    end
  end

  // =====================================================================
  // stack memories
  cpic_stack_mem #(
    .W  (24),
    .D  (`CPIC_PC_DEPTH),
    .AW (6)
  ) u_pc_stack (
    .clk     (clk),
    .wr_en   (pc_wr),
    .wr_addr (pc_count),
    .wr_data (ack_take ? pc_ret : pc_wdata),
    .rd_addr (pc_count_next - 6'd1),
    .rd_data (pc_top)
  );

  cpic_stack_mem #(
    .W  (16),
    .D  (`CPIC_STAT_DEPTH),
    .AW (4)
  ) u_stat_stack (
    .clk     (clk),
    .wr_en   (stat_wr),
    .wr_addr (stat_count[3:0]),
    .wr_data (mask_reg),
    .rd_addr (stat_count_next[3:0] - 4'd1),
    .rd_data (stat_top)
  );

  cpic_stack_mem #(
    .W  (24),
    .D  (`CPIC_LOOP_DEPTH),
    .AW (3)
  ) u_loop_stack (
    .clk     (clk),
    .wr_en   (loop_wr),
    .wr_addr (loop_count[2:0]),
    .wr_data (loop_wdata),
    .rd_addr (loop_count_next[2:0] - 3'd1),
    .rd_data (loop_top)
  );

  // =====================================================================
  // registers
  always @(posedge clk) begin
    if (rst) begin
      mask_reg       <= `CPIC_MASK_RST;
      latch_reg      <= `CPIC_LATCH_RST;
      insvc_reg      <= 16'h0000;
      nest_reg       <= 1'b0;
      gie_reg        <= 1'b0;
      stack_cond_reg <= 1'b1;
      pc_count       <= 6'd0;
      loop_count     <= 4'd0;
      stat_count     <= 5'd0;
      irq_valid      <= 1'b0;
      irq_index      <= 4'h0;
      irq_vector     <= 24'h000000;
      emu_irq        <= 1'b0;
      reg_rdata      <= 16'h0000;
      for (r = 0; r < 8; r = r + 1) begin
        route_reg[r] <= `CPIC_ROUTE_RST;
      end
    end else begin
      mask_reg       <= mask_next;
      latch_reg      <= latch_next;
      insvc_reg      <= insvc_next;
      gie_reg        <= gie_next;
      stack_cond_reg <= stack_cond;
      pc_count       <= pc_count_next;
      loop_count     <= loop_count_next;
      stat_count     <= stat_count_next;
      emu_irq        <= emu_req;
      // drop the request the cycle after an ack, latch is stale then
      irq_valid      <= sel[4] & ~ack_take;
      irq_index      <= sel[3:0];
      irq_vector     <= {20'h00000, sel[3:0]} << `CPIC_VEC_SHIFT;
      if (wr_ctrl) begin
        nest_reg <= reg_wdata[`CPIC_CTRL_NEST_BIT];
      end
      if (reg_wr && route_hit) begin
        route_reg[route_idx] <= reg_wdata;
      end
      if (reg_rd) begin
        case (reg_addr)
          `CPIC_ADDR_MASK:  reg_rdata <= mask_reg;
          `CPIC_ADDR_LATCH: reg_rdata <= latch_reg;
          `CPIC_ADDR_CTRL:  reg_rdata <= {14'h0000, gie_reg, nest_reg};
          `CPIC_ADDR_INSVC: reg_rdata <= insvc_reg;
          default: begin
            if (route_hit) begin
              reg_rdata <= route_reg[route_idx];
            end else begin
              reg_rdata <= 16'h0000;
            end
          end
        endcase
      end
    end
  end

endmodule // cpic_top

`default_nettype wire

/* sim/cpic_top_chk.sv */
// port-level assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module cpic_top_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        emu_req,
  input wire logic        ena_int,
  input wire logic        dis_int,
  input wire logic        irq_ack,
  input wire logic        rti,
  input wire logic        pc_push,
  input wire logic        pc_pop,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic        irq_valid,
  input wire logic [3:0]  irq_index,
  input wire logic [23:0] irq_vector,
  input wire logic        emu_irq,
  input wire logic [5:0]  pc_count,
  input wire logic [4:0]  stat_count
);
  logic      gie_m;
  wire logic take = irq_ack && irq_valid;
  // shadow of the global enable, dis wins like in the design
  always @(posedge clk)
    if (rst) gie_m <= 1'b0;
    else if (dis_int) gie_m <= 1'b0;
    else if (ena_int) gie_m <= 1'b1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  vec_map_a: assert property (irq_valid |->
    irq_vector == {15'h0000, irq_index, 5'h00}) else $error("bad vector");
  emu_copy_a: assert property (!$past(rst) |->
    emu_irq == $past(emu_req)) else $error("emu not copied");
  ack_gap_a: assert property (take |=> !irq_valid)
    else $error("offer kept after ack");
  stat_push_a: assert property (take && stat_count < 5'd16 |=>
    stat_count == $past(stat_count) + 5'd1) else $error("no status save");
  stat_pop_a: assert property (rti && !take && stat_count != 5'd0 |=>
    stat_count == $past(stat_count) - 5'd1) else $error("no status pop");
  pc_push_a: assert property (pc_push && !pc_pop && !take && !rti &&
    pc_count < 6'd33 |=> pc_count == $past(pc_count) + 6'd1)
    else $error("pc push lost");
  depth_cap_a: assert property (pc_count <= 6'd33 &&
    stat_count <= 5'd16) else $error("stack too deep");
  unmapped_rd_a: assert property (reg_rd && reg_addr >= 4'hC |=>
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  gie_gate_a: assert property (irq_valid && !gie_m && !$past(gie_m) |->
    irq_index == 4'h0) else $error("offer while disabled");
  cover property (take && irq_index == 4'h0);
  cover property (take && irq_index == 4'h1);
  cover property (pc_count == 6'd33);
  cover property (irq_valid && stat_count == 5'd1);
endmodule // cpic_top_chk

bind cpic_top cpic_top_chk chk_u (.clk(clk), .rst(rst), .emu_req(emu_req),
  .ena_int(ena_int), .dis_int(dis_int), .irq_ack(irq_ack), .rti(rti),
  .pc_push(pc_push), .pc_pop(pc_pop), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .irq_valid(irq_valid), .irq_index(irq_index),
  .irq_vector(irq_vector), .emu_irq(emu_irq), .pc_count(pc_count),
  .stat_count(stat_count));
`default_nettype wire

/* sim/cpic_core_model.sv */
// core sequencer model: takes offers, runs a handler, returns
`timescale 1ns/1ps
`default_nettype none
// ====================
// sequencer
module cpic_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  dly,
  input  wire logic        irq_valid,
  input  wire logic [23:0] irq_vector,
  output var  logic        irq_ack,
  output var  logic        rti,
  output wire logic [23:0] pc_ret,
  output var  logic [3:0]  n_taken
);
  logic [23:0] log_q [0:15];
  logic [3:0]  wt;
  logic [4:0]  cnt;
  // one return address is enough, only the push count is watched
  assign pc_ret = 24'h0000A5;
  always @(posedge clk) begin
    irq_ack <= 1'b0;
    rti <= 1'b0;
    if (rst) begin
      cnt <= 5'd0;
      wt <= 4'd0;
      n_taken <= 4'd0;
    end else if (irq_ack && irq_valid) begin
      log_q[n_taken] <= irq_vector;
      n_taken <= n_taken + 4'd1;
      // dly also stretches the handler, so offers can arrive inside it
      cnt <= {1'b0, dly} + 5'd4;
    end else if (cnt > 5'd1) begin
      cnt <= cnt - 5'd1;
    end else if (cnt == 5'd1) begin
      rti <= 1'b1;
      cnt <= 5'd0;
    end else if (irq_valid && !rti) begin
      // dly stretches the answer to model a busy core
      wt <= wt + 4'd1;
      if (wt >= dly) begin
        irq_ack <= 1'b1;
        wt <= 4'd0;
      end
    end
  end
endmodule // cpic_core_model
`default_nettype wire

/* sim/cpic_top_tb_top.sv */
// testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module cpic_top_tb_top;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        emu_req = 1'b0, soft_reset_req = 1'b0, pdown_req = 1'b0;
  logic        ena_int = 1'b0, dis_int = 1'b0, pc_push = 1'b0, pc_pop = 1'b0;
  logic [3:0]  reg_addr = 4'h0, dly = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [31:0] periph_req = 32'h00000000;
  wire logic   irq_ack, rti, irq_valid;
  wire logic [23:0] pc_ret, irq_vector;
  wire logic [15:0] reg_rdata;
  wire logic [5:0]  pc_count;
  wire logic [4:0]  stat_count;
  wire logic [3:0]  n_taken;
  int          n_mismatch = 0, total_checks = 0;
  cpic_top dut_u (.clk(clk), .rst(rst), .periph_req(periph_req),
    .emu_req(emu_req), .soft_reset_req(soft_reset_req),
    .pdown_req(pdown_req), .kernel_req(1'b0), .ena_int(ena_int),
    .dis_int(dis_int), .irq_ack(irq_ack), .rti(rti), .pc_ret(pc_ret),
    .pc_push(pc_push), .pc_pop(pc_pop), .pc_wdata(24'h00005A),
    .loop_push(1'b0), .loop_pop(1'b0), .loop_wdata(24'h000000),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_valid(irq_valid),
    .irq_index(), .irq_vector(irq_vector), .emu_irq(), .pc_top(),
    .loop_top(), .pc_count(pc_count), .loop_count(),
    .stat_count(stat_count));
  cpic_core_model core_u (.clk(clk), .rst(rst), .dly(dly),
    .irq_valid(irq_valid), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .rti(rti), .pc_ret(pc_ret), .n_taken(n_taken));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // waits until n offers were taken and every handler has returned
  task automatic wait_n(input logic [3:0] n);
    int i;
    for (i = 0; i < 100 && (n_taken !== n || stat_count !== 5'd0); i++)
      #5;
    chk(n_taken, n);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset();
    logic [15:0] d;
    chk(irq_valid, 1'b0);
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], d);
      chk(d, (i >= 4 && i < 12) ? 16'hFFFF : 16'h0000);
    end
  endtask
  task automatic t_route();
    logic [15:0] d;
    for (int k = 0; k < 16; k++) begin
      wr(4'h5, {8'hFF, k[3:0], 4'hF});
      @(posedge clk) periph_req <= 32'h00000020;
      @(posedge clk) periph_req <= 32'h00000000;
      rd(4'h1, d);
      chk(d, k < 12 ? 16'h0010 << k : 16'h0000);
      wr(4'h1, 16'h0000);
    end
    wr(4'h4, 16'hF22F);
    wr(4'hB, 16'hBFFF);
    @(posedge clk) periph_req <= 32'h80000004;
    @(posedge clk) periph_req <= 32'h00000000;
    rd(4'h1, d);
    chk(d, 16'h8040);
    wr(4'h1, 16'h0000);
  endtask
  task automatic t_prio();
    logic [15:0] d;
    @(posedge clk) ena_int <= 1'b1;
    @(posedge clk) ena_int <= 1'b0;
    wr(4'h0, 16'h0080);
    wr(4'h1, 16'h0880);
    wait_n(4'd1);
    rd(4'h1, d);
    chk(d, 16'h0800);
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0880);
    wr(4'h1, 16'h0880);
    wait_n(4'd3);
    chk(core_u.log_q[1], 24'h0000E0);
    chk(core_u.log_q[2], 24'h000160);
  endtask
  task automatic t_gate();
    logic [15:0] d;
    dly <= 4'd3;
    @(posedge clk) dis_int <= 1'b1;
    @(posedge clk) dis_int <= 1'b0;
    wr(4'h1, 16'h0080);
    @(posedge clk) pdown_req <= 1'b1;
    @(posedge clk);
    pdown_req <= 1'b0;
    soft_reset_req <= 1'b1;
    emu_req <= 1'b1;
    @(posedge clk);
    soft_reset_req <= 1'b0;
    emu_req <= 1'b0;
    wait_n(4'd4);
    chk(core_u.log_q[3], 24'h000000);
    rd(4'h1, d);
    chk(d, 16'h0082);
    wr(4'h1, 16'h0002);
    @(posedge clk) ena_int <= 1'b1;
    @(posedge clk) ena_int <= 1'b0;
    wait_n(4'd5);
    chk(core_u.log_q[4], 24'h000020);
    rd(4'h1, d);
    chk(d, 16'h0000);
  endtask
  task automatic t_stack();
    logic [15:0] d;
    @(posedge clk) pc_push <= 1'b1;
    repeat (34) @(posedge clk);
    pc_push <= 1'b0;
    #1 chk(pc_count, 6'd33);
    rd(4'h1, d);
    chk(d, 16'h0004);
    wr(4'h1, 16'h0000);
    @(posedge clk) pc_pop <= 1'b1;
    repeat (30) @(posedge clk);
    pc_pop <= 1'b0;
    rd(4'h1, d);
    chk(d, 16'h0000);
    @(posedge clk) pc_pop <= 1'b1;
    @(posedge clk) pc_pop <= 1'b0;
    rd(4'h1, d);
    chk(d, 16'h0004);
  endtask
  // nesting on: a higher offer must appear while a handler still runs
  task automatic t_nest();
    wr(4'h2, 16'h0001);
    @(posedge clk) dly <= 4'hF;
    wr(4'h1, 16'h0800);
    while (n_taken !== 4'd6) @(posedge clk);
    wr(4'h1, 16'h0080);
    repeat (2) @(posedge clk);
    #1 chk({stat_count, irq_valid, irq_vector}, {5'd1, 1'b1, 24'h0000E0});
    wait_n(4'd7);
    chk(core_u.log_q[6], 24'h0000E0);
    wr(4'h2, 16'h0000);
    @(posedge clk) dly <= 4'h0;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_prio();
    t_gate();
    t_stack();
    t_nest();
    wrap_up();
  end
  // run needs about 400 cycles, so 10k cycles means a hang
  initial begin
    #50000;
    n_mismatch++;
    wrap_up();
  end
endmodule // cpic_top_tb_top
`default_nettype wire
